// *** logic/oms_top.sv ***
// Operating mode selection, port mapping and external bus configuration
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps

module oms_top import oms_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic background_debug_pin,
	input wire logic mode_select_b,
	input wire logic mode_select_a,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic bus_req,
	input wire logic bus_we,
	input wire logic bus_word,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	output logic bus_busy,
	output logic bus_done,
	output logic [15:0] bus_rdata,
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe,
	input wire logic [7:0] port_e_in,
	output logic [7:0] port_e_out,
	output logic [7:0] port_e_oe,
	input wire logic bdm_enable_cmd,
	input wire logic bdm_activate_cmd,
	input wire logic bdm_exit_cmd,
	output logic [2:0] op_mode,
	output logic special_mode,
	output logic single_chip,
	output logic expanded_wide,
	output logic expanded_narrow,
	output logic periph_mode,
	output logic cpu_hold,
	output logic protect_en,
	output logic bdm_enabled,
	output logic background_debug_mode,
	output logic clock_stretch,
	output logic int_visibility,
	output logic bus_stop_in_wait,
	output logic [15:0] reg_block_base
);

	// ==========================================================
	// Pin synchronisers
	logic [2:0] strap_s1;
	logic [2:0] strap_s2;
	logic [7:0] pa_s1;
	logic [7:0] pa_s2;
	logic [7:0] pb_s1;
	logic [7:0] pb_s2;
	logic [7:0] pe_s1;
	logic [7:0] pe_s2;

	// No reset here: the strap must keep flowing while reset is held
	always_ff @(posedge mclk) begin
		if (clk_en) begin
			strap_s1 <= {background_debug_pin, mode_select_b, mode_select_a};
			strap_s2 <= strap_s1;
			pa_s1 <= port_a_in;
			pa_s2 <= pa_s1;
			pb_s1 <= port_b_in;
			pb_s2 <= pb_s1;
			pe_s1 <= port_e_in;
			pe_s2 <= pe_s1;
		end
	end

	// ==========================================================
	// Strap decode
	// Reserved normal code collapses onto the peripheral mode
	wire logic strap_rsv = (strap_s2 == OMS_NRM_RSV);
	wire logic [2:0] strap_mode = strap_rsv ? OMS_SPC_PERIPH : strap_s2;

	// ==========================================================
	// State
	logic [2:0] mode_q;
	logic estr_q;
	logic ivis_q;
	logic ebswai_q;
	logic eme_q;
	logic mode_seen;
	logic [4:0] map_q;
	logic map_seen;
	logic released;
	logic bdm_act_q;
	logic bdm_en_q;
	logic [7:0] porta_dat;
	logic [7:0] portb_dat;
	logic [7:0] port_a_direction_reg;
	logic [7:0] port_b_direction_reg;
	logic [7:0] port_e_data_reg_dat;
	logic [7:0] port_e_direction_reg;

	// ==========================================================
	// Mode classification
	wire logic is_special = !mode_q[2];
	wire logic is_periph = (mode_q == OMS_SPC_PERIPH);
	wire logic is_single = (mode_q[1:0] == OMS_AB_SINGLE);
	wire logic is_narrow = (mode_q[1:0] == 2'h1);
	wire logic is_wide = (mode_q[1:0] == 2'h3);
	wire logic is_expanded = is_narrow || is_wide;

	// ==========================================================
	// Register map presence
	wire logic ab_in_map = is_single;
	wire logic e_in_map = !is_periph && !(is_expanded && eme_q);
	wire logic mode_in_map = !is_periph;

	wire logic hit_porta = (reg_addr == OMS_PORTA_OFS) && ab_in_map;
	wire logic hit_portb = (reg_addr == OMS_PORTB_OFS) && ab_in_map;
	wire logic hit_port_a_direction_reg = (reg_addr == OMS_PORT_A_DIRECTION_REG_OFS) && ab_in_map;
	wire logic hit_port_b_direction_reg = (reg_addr == OMS_PORT_B_DIRECTION_REG_OFS) && ab_in_map;
	wire logic hit_port_e_data_reg = (reg_addr == OMS_PORT_E_DATA_REG_OFS) && e_in_map;
	wire logic hit_port_e_direction_reg = (reg_addr == OMS_PORT_E_DIRECTION_REG_OFS) && e_in_map;
	wire logic hit_mode = (reg_addr == OMS_MODE_OFS) && mode_in_map;
	wire logic hit_map = (reg_addr == OMS_MAP_OFS);

	wire logic wr_mode = reg_wr && hit_mode;
	wire logic wr_map = reg_wr && hit_map;

	// ==========================================================
	// Mode register write qualification
	// Normal modes get one shot except EBSWAI; special modes skip the first write except ESTR, and never take EBSWAI
	wire logic norm_once = !is_special && !mode_seen;
	wire logic spec_late = is_special && mode_seen;
	wire logic [1:0] new_ab = reg_wdata[OMS_MB_B:OMS_MB_A];
	wire logic ab_legal = (new_ab != OMS_AB_RESERVED);
	wire logic ab_ok = wr_mode && (norm_once || spec_late) && ab_legal;
	wire logic special_mode_low_ok = wr_mode && spec_late;
	wire logic estr_ok = wr_mode && (norm_once || is_special);
	wire logic late_ok = wr_mode && (norm_once || spec_late);
	wire logic ebswai_ok = wr_mode && !is_special;
	wire logic map_ok = wr_map && (is_special || !map_seen);

	wire logic next_special_mode_low = special_mode_low_ok ? reg_wdata[OMS_MB_SPECIAL_MODE_LOW] : mode_q[2];
	wire logic [1:0] next_ab = ab_ok ? new_ab : mode_q[1:0];
	wire logic [2:0] next_mode = {next_special_mode_low, next_ab};

	// Leaving special while the select bits stay put keeps a legal code
	wire logic next_legal = (next_mode != OMS_NRM_RSV) && (next_mode != OMS_SPC_PERIPH);

	// ==========================================================
	// Mode and mapping registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			// Synchronous reset, so the last sample before release wins
			mode_q <= strap_mode;
			estr_q <= OMS_ESTR_RESET;
			ivis_q <= !strap_mode[2];
			ebswai_q <= OMS_EBSWAI_RESET;
			eme_q <= !strap_mode[2];
			mode_seen <= 1'b0;
			map_q <= OMS_MAP_RESET;
			map_seen <= 1'b0;
		end else if (clk_en) begin
			if (wr_mode) mode_seen <= 1'b1;
			if ((ab_ok || special_mode_low_ok) && next_legal) mode_q <= next_mode;
			if (estr_ok) estr_q <= reg_wdata[OMS_MB_ESTR];
			if (late_ok) ivis_q <= reg_wdata[OMS_MB_IVIS];
			if (late_ok) eme_q <= reg_wdata[OMS_MB_EME];
			if (ebswai_ok) ebswai_q <= reg_wdata[OMS_MB_EBSWAI];
			if (wr_map) map_seen <= 1'b1;
			if (map_ok) map_q <= reg_wdata[OMS_MAP_LSB +: 5];
		end
	end

	// ==========================================================
	// Port data and direction registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			porta_dat <= OMS_PORT_RESET;
			portb_dat <= OMS_PORT_RESET;
			port_a_direction_reg <= OMS_PORT_RESET;
			port_b_direction_reg <= OMS_PORT_RESET;
			port_e_data_reg_dat <= OMS_PORT_RESET;
			port_e_direction_reg <= OMS_PORT_RESET;
		end else if (clk_en && reg_wr) begin
			if (hit_porta) porta_dat <= reg_wdata;
			if (hit_portb) portb_dat <= reg_wdata;
			if (hit_port_a_direction_reg) port_a_direction_reg <= reg_wdata;
			if (hit_port_b_direction_reg) port_b_direction_reg <= reg_wdata;
			if (hit_port_e_data_reg) port_e_data_reg_dat <= reg_wdata;
			if (hit_port_e_direction_reg) port_e_direction_reg <= reg_wdata;
		end
	end

	// ==========================================================
	// Background debug state
	wire logic bdm_allowed = !is_periph;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			released <= 1'b0;
			bdm_act_q <= 1'b0;
			bdm_en_q <= 1'b0;
		end else if (clk_en) begin
			if (!released) begin
				released <= 1'b1;
				bdm_act_q <= (mode_q == OMS_SPC_SC);
				bdm_en_q <= (mode_q == OMS_SPC_SC);
			end else begin
				if (bdm_enable_cmd && bdm_allowed) bdm_en_q <= 1'b1;
				if (bdm_exit_cmd) bdm_act_q <= 1'b0;
				else if (bdm_activate_cmd && bdm_en_q && bdm_allowed) bdm_act_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Register read path
	wire logic [7:0] mode_rd = {mode_q, estr_q, ivis_q, ebswai_q, 1'b0, eme_q};
	wire logic [7:0] map_rd = {map_q, 3'h0};
	wire logic [7:0] rd_mux =
		hit_porta ? (port_a_direction_reg & porta_dat) | (~port_a_direction_reg & pa_s2) :
		hit_portb ? (port_b_direction_reg & portb_dat) | (~port_b_direction_reg & pb_s2) :
		hit_port_a_direction_reg ? port_a_direction_reg :
		hit_port_b_direction_reg ? port_b_direction_reg :
		hit_port_e_data_reg ? (port_e_direction_reg & port_e_data_reg_dat) | (~port_e_direction_reg & pe_s2) :
		hit_port_e_direction_reg ? port_e_direction_reg :
		hit_mode ? mode_rd :
		hit_map ? map_rd :
		8'h00;

	always_ff @(posedge mclk) begin
		if (!resetn) reg_rdata <= 8'h00;
		else if (clk_en && reg_rd) reg_rdata <= rd_mux;
	end

	// ==========================================================
	// External bus
	// Requests only start while expanded; peripheral mode has no CPU master
	wire logic seq_busy;
	wire logic seq_drive;
	wire logic [7:0] seq_a;
	wire logic [7:0] seq_b;
	wire logic bus_start = bus_req && is_expanded && !seq_busy;

	oms_bus_seq u_seq (
		.mclk(mclk),
		.resetn(resetn),
		.clk_en(clk_en),
		.narrow(is_narrow),
		.start(bus_start),
		.write(bus_we),
		.word(bus_word),
		.addr(bus_addr),
		.wdata(bus_wdata),
		.a_in(pa_s2),
		.b_in(pb_s2),
		.busy(seq_busy),
		.done(bus_done),
		.rdata(bus_rdata),
		.a_out(seq_a),
		.b_out(seq_b),
		.drive_data(seq_drive)
	);

	// Stalls non-expanded modes so requests are never silently taken
	assign bus_busy = seq_busy || !is_expanded;

	// ==========================================================
	// Port pin drive
	// Narrow data phase leaves port B holding the low address
	wire logic b_drive = seq_drive || (is_narrow && seq_busy);
	assign port_a_out = is_single ? porta_dat : seq_a;
	assign port_b_out = is_single ? portb_dat : seq_b;
	assign port_a_oe = is_single ? port_a_direction_reg : (is_expanded ? {8{seq_drive}} : 8'h00);
	assign port_b_oe = is_single ? port_b_direction_reg : (is_expanded ? {8{b_drive}} : 8'h00);
	assign port_e_out = port_e_data_reg_dat;
	assign port_e_oe = e_in_map ? port_e_direction_reg : 8'h00;

	// ==========================================================
	// Status outputs
	assign op_mode = mode_q;
	assign special_mode = is_special;
	assign single_chip = is_single;
	assign expanded_wide = is_wide;
	assign expanded_narrow = is_narrow;
	assign periph_mode = is_periph;
	assign cpu_hold = is_periph;
	assign protect_en = !is_special;
	assign bdm_enabled = bdm_en_q;
	assign background_debug_mode = bdm_act_q;
	assign clock_stretch = estr_q || is_expanded;
	assign int_visibility = ivis_q && !is_single;
	assign bus_stop_in_wait = ebswai_q;
	assign reg_block_base = {map_q, 11'h000};

endmodule : oms_top

// *** logic/oms_pkg.sv ***
// Constants, mode codes and state types for operating mode selection
package oms_pkg;

	// ==========================================================
	// Register offsets within the register block
	localparam logic [9:0] OMS_PORTA_OFS = 10'h000;
	localparam logic [9:0] OMS_PORTB_OFS = 10'h001;
	localparam logic [9:0] OMS_PORT_A_DIRECTION_REG_OFS = 10'h002;
	localparam logic [9:0] OMS_PORT_B_DIRECTION_REG_OFS = 10'h003;
	localparam logic [9:0] OMS_PORT_E_DATA_REG_OFS = 10'h008;
	localparam logic [9:0] OMS_PORT_E_DIRECTION_REG_OFS = 10'h009;
	localparam logic [9:0] OMS_MODE_OFS = 10'h00b;
	localparam logic [9:0] OMS_MAP_OFS = 10'h011;

	// ==========================================================
	// Mode and map register field positions
	localparam int OMS_MB_SPECIAL_MODE_LOW = 7;
	localparam int OMS_MB_B = 6;
	localparam int OMS_MB_A = 5;
	localparam int OMS_MB_ESTR = 4;
	localparam int OMS_MB_IVIS = 3;
	localparam int OMS_MB_EBSWAI = 2;
	localparam int OMS_MB_EME = 0;
	localparam int OMS_MAP_LSB = 3;

	// ==========================================================
	// Reset values, select codes and address step
	localparam logic [7:0] OMS_PORT_RESET = 8'h00;
	localparam logic [4:0] OMS_MAP_RESET = 5'h00;
	localparam logic OMS_ESTR_RESET = 1'b1;
	localparam logic OMS_EBSWAI_RESET = 1'b0;
	localparam logic [1:0] OMS_AB_RESERVED = 2'h2;
	localparam logic [1:0] OMS_AB_SINGLE = 2'h0;
	localparam logic [15:0] OMS_ADDR_STEP = 16'h0001;

	// ==========================================================
	// Operating modes: {special_mode_low, mode_select_b, mode_select_a}
	typedef enum logic [2:0] {
		OMS_SPC_SC = 3'h0,
		OMS_SPC_NAR = 3'h1,
		OMS_SPC_PERIPH = 3'h2,
		OMS_SPC_WIDE = 3'h3,
		OMS_NRM_SC = 3'h4,
		OMS_NRM_NAR = 3'h5,
		OMS_NRM_RSV = 3'h6,
		OMS_NRM_WIDE = 3'h7
	} oms_mode_t;

	// ==========================================================
	// External bus sequencer states, Gray from IDLE to DATA2 along the word path
	typedef enum logic [2:0] {
		OMS_SQ_IDLE = 3'h0,
		OMS_SQ_ADDR = 3'h1,
		OMS_SQ_DATA = 3'h3,
		OMS_SQ_ADDR2 = 3'h2,
		OMS_SQ_DATA2 = 3'h6
	} oms_seq_t;

endpackage : oms_pkg

// *** logic/oms_bus_seq.sv ***
// Multiplexed external bus sequencer for wide and narrow modes
`timescale 1ns/1ps
module oms_bus_seq import oms_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic narrow,
	input wire logic start,
	input wire logic write,
	input wire logic word,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [7:0] a_in,
	input wire logic [7:0] b_in,
	output logic busy,
	output logic done,
	output logic [15:0] rdata,
	output logic [7:0] a_out,
	output logic [7:0] b_out,
	output logic drive_data
);

	// ==========================================================
	// Sequencer
	oms_seq_t state;
	oms_seq_t next_state;
	logic wr_q;
	logic word_q;
	logic narrow_q;
	logic [15:0] addr_q;
	logic [15:0] data_q;
	wire logic [15:0] addr_inc = addr_q + OMS_ADDR_STEP;
	wire logic second = narrow_q && word_q;

	assign busy = (state != OMS_SQ_IDLE);

	always_comb begin
		next_state = state;
		unique case (state)
			OMS_SQ_IDLE: if (start) next_state = OMS_SQ_ADDR;
			OMS_SQ_ADDR: next_state = OMS_SQ_DATA;
			OMS_SQ_DATA: next_state = second ? OMS_SQ_ADDR2 : OMS_SQ_IDLE;
			OMS_SQ_ADDR2: next_state = OMS_SQ_DATA2;
			OMS_SQ_DATA2: next_state = OMS_SQ_IDLE;
			default: next_state = OMS_SQ_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state <= OMS_SQ_IDLE;
			wr_q <= 1'b0;
			word_q <= 1'b0;
			narrow_q <= 1'b0;
			addr_q <= 16'h0000;
			data_q <= 16'h0000;
			rdata <= 16'h0000;
			done <= 1'b0;
			a_out <= 8'h00;
			b_out <= 8'h00;
			drive_data <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			done <= 1'b0;
			unique case (next_state)
				OMS_SQ_ADDR: begin
					// Address phase: A carries high, B low
					a_out <= addr[15:8];
					b_out <= addr[7:0];
					drive_data <= 1'b1;
				end
				OMS_SQ_DATA: begin
					drive_data <= wr_q;
					a_out <= data_q[15:8];
					if (!narrow_q) b_out <= data_q[7:0];
				end
				OMS_SQ_ADDR2: begin
					a_out <= addr_inc[15:8];
					b_out <= addr_inc[7:0];
					drive_data <= 1'b1;
				end
				OMS_SQ_DATA2: begin
					drive_data <= wr_q;
					a_out <= data_q[7:0];
				end
				default: drive_data <= 1'b0;
			endcase
			if (state == OMS_SQ_IDLE && start) begin
				wr_q <= write;
				word_q <= word;
				narrow_q <= narrow;
				addr_q <= addr;
				data_q <= wdata;
			end
			if (state == OMS_SQ_DATA) begin
				if (narrow_q) rdata <= word_q ? {a_in, rdata[7:0]} : {8'h00, a_in};
				else rdata <= {a_in, b_in};
				done <= !second;
			end
			if (state == OMS_SQ_DATA2) begin
				rdata <= {rdata[15:8], a_in};
				done <= 1'b1;
			end
		end
	end

endmodule : oms_bus_seq

// *** bench/oms_props.sv ***
// Concurrent checks on the mode selection top ports
`timescale 1ns/1ps
module oms_props import oms_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic bus_req,
	input wire logic bus_we,
	input wire logic bus_word,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_busy,
	input wire logic bus_done,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_a_oe,
	input wire logic [2:0] op_mode,
	input wire logic special_mode,
	input wire logic single_chip,
	input wire logic expanded_wide,
	input wire logic expanded_narrow,
	input wire logic periph_mode,
	input wire logic cpu_hold,
	input wire logic protect_en,
	input wire logic background_debug_mode
);
	// ====
	// Mode and transfer relations
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire take = bus_req && !bus_busy;

	periph_cpu_a: assert property (periph_mode |-> cpu_hold && bus_busy)
		else $error("cpu not held in peripheral mode");
	single_bus_a: assert property (single_chip |-> bus_busy && !bus_done)
		else $error("bus active in single chip");
	decode_a: assert property (expanded_wide == (op_mode[1:0] == 2'h3)
		&& special_mode == !op_mode[2])
		else $error("mode decode wrong");
	protect_a: assert property (protect_en == op_mode[2])
		else $error("protection level wrong");
	mode_hold_a: assert property ($past(resetn) && !$past(reg_wr) |-> $stable(op_mode))
		else $error("mode changed without write");
	periph_lock_a: assert property ($past(resetn) |->
		(op_mode == OMS_SPC_PERIPH) == ($past(op_mode) == OMS_SPC_PERIPH))
		else $error("peripheral mode changed outside reset");
	wide_addr_a: assert property (take && expanded_wide |=> port_a_oe == 8'hff
		&& {port_a_out, port_b_out} == $past(bus_addr))
		else $error("wide address phase wrong");
	wide_done_a: assert property (take && expanded_wide |->
		##1 !bus_done ##1 !bus_done ##1 bus_done)
		else $error("wide transfer length wrong");
	narrow_incr_a: assert property (take && expanded_narrow && bus_word |->
		##3 {port_a_out, port_b_out} == $past(bus_addr, 3) + OMS_ADDR_STEP)
		else $error("second address not incremented");
	narrow_data_a: assert property (take && expanded_narrow && bus_word && bus_we |->
		##2 port_a_out == $past(bus_wdata[15:8], 2)
		##2 port_a_out == $past(bus_wdata[7:0], 4))
		else $error("narrow byte order wrong");
	narrow_done_a: assert property (take && expanded_narrow && bus_word |->
		##5 bus_done && !$past(bus_done))
		else $error("narrow word length wrong");
	ssc_bdm_a: assert property ($rose(resetn) && op_mode == OMS_SPC_SC
		|=> background_debug_mode)
		else $error("debug not active after reset");
endmodule : oms_props

// *** bench/oms_ext_mem.sv ***
// External memory model recording multiplexed bus cycles
`timescale 1ns/1ps
module oms_ext_mem (
	input wire logic mclk,
	input wire logic [7:0] a_out,
	input wire logic [7:0] a_oe,
	input wire logic [7:0] b_out,
	input wire logic [7:0] b_oe,
	output logic [7:0] a_pin,
	output logic [7:0] b_pin
);
	// ====
	// Pins and capture
	logic [7:0] pat = 8'h3c;
	logic [7:0] qa[$];
	logic [7:0] qb[$];
	// Released lines other than bit 0 toggle so stale data never looks valid
	always @(posedge mclk) pat <= ~pat ^ 8'h01;
	assign a_pin = (a_oe & a_out) | (~a_oe & pat);
	assign b_pin = (b_oe & b_out) | (~b_oe & ~pat);
	// Never issues debug commands; accepts every cycle with no wait
	always @(posedge mclk) begin
		if (a_oe == 8'hff) qa.push_back(a_out);
		if (b_oe == 8'hff) qb.push_back(b_out);
	end
endmodule : oms_ext_mem

// *** bench/test_operating_mode_select.sv ***
// Self-checking bench for operating mode selection
`timescale 1ns/1ps
module test_operating_mode_select import oms_pkg::*;;
	// ====
	// Signals
	logic mclk = 1'h0, resetn = 1'h0, clk_en = 1'h1;
	logic background_debug_pin = 1'h1, mode_select_b = 1'h0, mode_select_a = 1'h0;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, port_e_in = 8'h00;
	logic reg_wr = 1'h0, reg_rd = 1'h0, bus_req = 1'h0, bus_we = 1'h1, bus_word = 1'h1;
	logic bus_busy, bus_done, special_mode, single_chip, expanded_wide, expanded_narrow;
	logic periph_mode, cpu_hold, protect_en, bdm_enabled, background_debug_mode;
	logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000;
	logic [7:0] port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe;
	logic [7:0] port_e_out, port_e_oe;
	logic clock_stretch, int_visibility, bus_stop_in_wait;
	logic [15:0] reg_block_base, bus_rdata;
	logic [2:0] cmd = 3'h0, op_mode;
	logic [7:0] wv[3] = '{8'h20, 8'h40, 8'hb0};
	int n_errors = 0, checked = 0, seed = 32'h76218bbb;

	always #2.5 mclk = ~mclk;
	always @(posedge mclk) port_e_in <= 8'($random(seed));

	oms_top uut (.mclk, .resetn, .clk_en, .background_debug_pin, .mode_select_b,
		.mode_select_a, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_req,
		.bus_we, .bus_word, .bus_addr, .bus_wdata, .bus_busy, .bus_done, .bus_rdata,
		.port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out, .port_b_oe,
		.port_e_in, .port_e_out, .port_e_oe, .bdm_enable_cmd(cmd[0]),
		.bdm_activate_cmd(cmd[1]), .bdm_exit_cmd(cmd[2]), .op_mode, .special_mode,
		.single_chip, .expanded_wide, .expanded_narrow, .periph_mode, .cpu_hold, .protect_en,
		.bdm_enabled, .background_debug_mode, .clock_stretch, .int_visibility,
		.bus_stop_in_wait, .reg_block_base);
	oms_ext_mem mem (.mclk, .a_out(port_a_out), .a_oe(port_a_oe), .b_out(port_b_out),
		.b_oe(port_b_oe), .a_pin(port_a_in), .b_pin(port_b_in));

	// ====
	// Tasks
	task chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr
	task rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask : rd
	task pulse(input logic [2:0] v);
		@(posedge mclk);
		cmd <= v;
		@(posedge mclk);
		cmd <= 3'h0;
		#1;
	endtask : pulse
	// Waits a fixed span so the model sees the whole transfer
	task bus(input logic [15:0] a, input logic [15:0] d, output int k);
		@(posedge mclk);
		bus_req <= 1'h1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge mclk);
		bus_req <= 1'h0;
		k = 99;
		for (int i = 1; i < 12; i++) begin
			@(posedge mclk);
			#1;
			if (k == 99 && bus_done === 1'h1) k = i;
		end
	endtask : bus
	task test_done;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	// ====
	// Scenarios
	initial begin
		logic [7:0] rv;
		logic [15:0] a, d, a1;
		logic [2:0] m;
		logic [1:0] ab;
		logic [7:0] ea[$];
		logic [7:0] eb[$];
		int k, ek;
		bit sc, pe, first;
		for (int c = 0; c < 8; c++) begin
			{background_debug_pin, mode_select_b, mode_select_a} <= 3'(c);
			resetn <= 1'h0;
			tick(10);
			resetn <= 1'h1;
			m = (c == 6) ? 3'h2 : 3'(c);
			ab = m[1:0];
			sc = (ab == 2'h0);
			pe = sc || m[2];
			tick(2);
			#1;
			chk({op_mode, special_mode, protect_en}, {m, ~m[2], m[2]});
			chk({single_chip, expanded_narrow, expanded_wide, periph_mode, cpu_hold},
				{sc, ab == 2'h1, ab == 2'h3, m == 3'h2, m == 3'h2});
			chk(background_debug_mode, m == 3'h0);
			chk({clock_stretch, int_visibility, bus_stop_in_wait}, {1'b1, ~m[2] & ~sc, 1'b0});
			if (m != 3'h2) begin
				rd(OMS_MODE_OFS, rv);
				chk(rv, {m, 1'h1, ~m[2], 2'h0, ~m[2]});
			end
			wr(OMS_PORTA_OFS, 8'ha5);
			wr(OMS_PORT_A_DIRECTION_REG_OFS, 8'hff);
			wr(OMS_PORT_E_DATA_REG_OFS, 8'h3c);
			wr(OMS_PORT_E_DIRECTION_REG_OFS, 8'hff);
			#1;
			chk(port_a_oe, sc ? 8'hff : 8'h00);
			if (sc) chk(port_a_out, 8'ha5);
			chk(port_e_oe, pe ? 8'hff : 8'h00);
			if (pe) chk(port_e_out, 8'h3c);
			// First map write is honoured in every mode
			wr(OMS_MAP_OFS, 8'h28);
			#1;
			chk(reg_block_base, 16'h2800);
			rd(OMS_MAP_OFS, rv);
			chk(rv, 8'h28);
			a = 16'($random(seed));
			d = 16'($random(seed));
			// Low byte all ones forces a carry on the second address
			if (ab == 2'h1) a[7:0] = 8'hff;
			a1 = a + 16'h0001;
			mem.qa.delete();
			mem.qb.delete();
			bus(a, d, k);
			ek = (ab == 2'h3) ? 2 : (ab == 2'h1) ? 4 : 99;
			chk(16'(k), 16'(ek));
			if (ab == 2'h3) begin
				ea = '{a[15:8], d[15:8]};
				eb = '{a[7:0], d[7:0]};
			end else begin
				ea = '{a[15:8], d[15:8], a1[15:8], d[7:0]};
				eb = '{a[7:0]};
			end
			if (ek != 99) begin
				chk(16'(mem.qa.size()), 16'(ea.size()));
				foreach (ea[i]) chk(mem.qa[i], ea[i]);
				foreach (eb[i]) chk(mem.qb[i], eb[i]);
			end
			first = 1'b0;
			foreach (wv[j]) begin
				wr(OMS_MODE_OFS, wv[j]);
				if (m != 3'h2) begin
					if (!first && m[2] && wv[j][6:5] != 2'h2) m[1:0] = wv[j][6:5];
					if (first && !m[2] && wv[j][6:5] != 2'h2) m = wv[j][7:5];
					first = 1'b1;
				end
				#1;
				chk(op_mode, m);
			end
			// Debug commands only in the normal modes, not the reserved code
			if (c[2] && c != 6) begin
				pulse(3'h2);
				chk(background_debug_mode, 1'h0);
				pulse(3'h1);
				chk(bdm_enabled, 1'h1);
				pulse(3'h2);
				chk(background_debug_mode, 1'h1);
			end
		end
		test_done();
	end

	initial begin
		#50000;
		n_errors++;
		test_done();
	end
endmodule : test_operating_mode_select

bind oms_top oms_props u_props (.mclk, .resetn, .reg_wr, .bus_req, .bus_we, .bus_word,
	.bus_addr, .bus_wdata, .bus_busy, .bus_done, .port_a_out, .port_b_out, .port_a_oe,
	.op_mode, .special_mode, .single_chip, .expanded_wide, .expanded_narrow, .periph_mode,
	.cpu_hold, .protect_en, .background_debug_mode);
